// [erlt_timer.sv]
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "erlt_defines.svh"

module erlt_timer (
   input  logic                    aclk,
   input  logic                    aresetn,
   input  logic [`ERLT_ADDR_W-1:0] s_axi_awaddr,
   input  logic                    s_axi_awvalid,
   output logic                    s_axi_awready,
   input  logic [31:0]             s_axi_wdata,
   input  logic [3:0]              s_axi_wstrb,
   input  logic                    s_axi_wvalid,
   output logic                    s_axi_wready,
   output logic [1:0]              s_axi_bresp,
   output logic                    s_axi_bvalid,
   input  logic                    s_axi_bready,
   input  logic [`ERLT_ADDR_W-1:0] s_axi_araddr,
   input  logic                    s_axi_arvalid,
   output logic                    s_axi_arready,
   output logic [31:0]             s_axi_rdata,
   output logic [1:0]              s_axi_rresp,
   output logic                    s_axi_rvalid,
   input  logic                    s_axi_rready,
   input  logic [`ERLT_PSC_W-1:0]  prescale_count,
   input  logic                    event_input_pin,
   output logic                    cpu_irq
);

   ////////////////////////////////////////////////////////////////////////////
   // functions

   // word address to register; low two bits ignored
   function automatic erlt_pkg::erlt_reg_e decode(
      input logic [`ERLT_ADDR_W-1:0] addr
   );
      erlt_pkg::erlt_reg_e r;
      r = erlt_pkg::ERLT_REG_NONE;
      unique case (addr[`ERLT_ADDR_W-1:2])
         `ERLT_IDX_MODE:  r = erlt_pkg::ERLT_REG_MODE;
         `ERLT_IDX_COUNT: r = erlt_pkg::ERLT_REG_COUNT;
         `ERLT_IDX_IRQ:   r = erlt_pkg::ERLT_REG_IRQ;
         `ERLT_IDX_IEN:   r = erlt_pkg::ERLT_REG_IEN;
         `ERLT_IDX_EDGE:  r = erlt_pkg::ERLT_REG_EDGE;
         default:         r = erlt_pkg::ERLT_REG_NONE;
      endcase
      return r;
   endfunction

   // prescaler tap for each internal rate
   function automatic logic [3:0] tap_of(input erlt_pkg::erlt_clk_e sel);
      logic [3:0] t;
      t = `ERLT_TAP_8192;
      unique case (sel)
         erlt_pkg::ERLT_CLK_8192: t = `ERLT_TAP_8192;
         erlt_pkg::ERLT_CLK_2048: t = `ERLT_TAP_2048;
         erlt_pkg::ERLT_CLK_512:  t = `ERLT_TAP_512;
         erlt_pkg::ERLT_CLK_256:  t = `ERLT_TAP_256;
         erlt_pkg::ERLT_CLK_128:  t = `ERLT_TAP_128;
         erlt_pkg::ERLT_CLK_32:   t = `ERLT_TAP_32;
         erlt_pkg::ERLT_CLK_8:    t = `ERLT_TAP_8;
         erlt_pkg::ERLT_CLK_EXT:  t = `ERLT_TAP_8;
      endcase
      return t;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // declarations

   logic                    aw_have_q;
   logic                    aw_have_d;
   logic                    w_have_q;
   logic                    w_have_d;
   logic                    awready_q;
   logic                    wready_q;
   logic                    bvalid_q;
   logic [1:0]              bresp_q;
   logic [`ERLT_ADDR_W-1:0] awaddr_q;
   logic [7:0]              wbyte_q;
   logic                    wlane_q;
   logic                    aw_take;
   logic                    w_take;
   logic                    do_wr;
   erlt_pkg::erlt_reg_e     wr_reg;
   logic                    wr_ok;
   logic                    arready_q;
   logic                    rvalid_q;
   logic [31:0]             rdata_q;
   logic [1:0]              rresp_q;
   logic                    ar_take;
   erlt_pkg::erlt_reg_e     rd_reg;
   logic [7:0]              rd_byte;
   erlt_pkg::erlt_mode_s    mode_q;
   logic [7:0]              count_q;
   logic [7:0]              reload_q;
   logic                    flag_q;
   logic                    ien_q;
   logic                    edge_sel_q;
   logic                    irq_q;
   logic                    psc_prev_q;
   logic                    psc_bit;
   logic                    ev_s1_q;
   logic                    ev_s2_q;
   logic                    ev_s3_q;
   logic                    ev_edge;
   logic                    tick;
   logic                    load;
   logic                    ovf;
   logic                    clr;

   ////////////////////////////////////////////////////////////////////////////
   // write address and data, taken in either order

   assign aw_take   = s_axi_awvalid & awready_q;
   assign w_take    = s_axi_wvalid & wready_q;
   assign do_wr     = aw_have_q & w_have_q & ~bvalid_q;
   assign aw_have_d = (aw_have_q | aw_take) & ~do_wr;
   assign w_have_d  = (w_have_q | w_take) & ~do_wr;
   assign wr_reg    = decode(awaddr_q);
   // registers are 8 bits wide, so only byte lane 0 writes
   assign wr_ok     = do_wr & wlane_q;

   // holding flags; ready drops while a beat is held
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q <= 1'b0;
         w_have_q  <= 1'b0;
         awready_q <= 1'b0;
         wready_q  <= 1'b0;
      end else begin
         aw_have_q <= aw_have_d;
         w_have_q  <= w_have_d;
         awready_q <= ~aw_have_d;
         wready_q  <= ~w_have_d;
      end
   end

   // captured address and data beat
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awaddr_q <= '0;
         wbyte_q  <= 8'h00;
         wlane_q  <= 1'b0;
      end else begin
         if (aw_take) begin
            awaddr_q <= s_axi_awaddr;
         end
         if (w_take) begin
            wbyte_q <= s_axi_wdata[7:0];
            wlane_q <= s_axi_wstrb[0];
         end
      end
   end

   // write response one cycle after both halves are held
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_q <= 1'b0;
         bresp_q  <= `ERLT_RESP_OKAY;
      end else if (do_wr) begin
         bvalid_q <= 1'b1;
         bresp_q  <= (wr_reg == erlt_pkg::ERLT_REG_NONE) ?
                     `ERLT_RESP_SLVERR : `ERLT_RESP_OKAY;
      end else if (s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read channel

   assign ar_take = s_axi_arvalid & arready_q;
   assign rd_reg  = decode(s_axi_araddr);

   // read mux; the shared address returns the live counter
   always_comb begin
      rd_byte = 8'h00;
      unique case (rd_reg)
         erlt_pkg::ERLT_REG_MODE:  rd_byte = {mode_q.reload, 4'h0, mode_q.sel}
                                             | `ERLT_MODE_RSVD;
         erlt_pkg::ERLT_REG_COUNT: rd_byte = count_q;
         erlt_pkg::ERLT_REG_IRQ:   rd_byte = {7'h00, flag_q};
         erlt_pkg::ERLT_REG_IEN:   rd_byte = {7'h00, ien_q};
         erlt_pkg::ERLT_REG_EDGE:  rd_byte = {7'h00, edge_sel_q};
         erlt_pkg::ERLT_REG_NONE:  rd_byte = 8'h00;
      endcase
   end

   // data captured on the taking edge, held until rready
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_q <= 1'b0;
         rvalid_q  <= 1'b0;
         rdata_q   <= 32'h0000_0000;
         rresp_q   <= `ERLT_RESP_OKAY;
      end else if (ar_take) begin
         arready_q <= 1'b0;
         rvalid_q  <= 1'b1;
         rdata_q   <= {24'h00_0000, rd_byte};
         rresp_q   <= (rd_reg == erlt_pkg::ERLT_REG_NONE) ?
                      `ERLT_RESP_SLVERR : `ERLT_RESP_OKAY;
      end else if (rvalid_q & s_axi_rready) begin
         rvalid_q  <= 1'b0;
         arready_q <= 1'b1;
      end else if (!rvalid_q) begin
         arready_q <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // control registers

   // mode: only bit 7 and the clock select are stored
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode_q <= erlt_pkg::erlt_mode_s'(4'h0);
      end else if (wr_ok && wr_reg == erlt_pkg::ERLT_REG_MODE) begin
         mode_q.reload <= wbyte_q[`ERLT_BIT_RELOAD];
         mode_q.sel    <= erlt_pkg::erlt_clk_e'(wbyte_q[2:0]);
      end
   end

   // enable and edge select
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ien_q      <= 1'b0;
         edge_sel_q <= 1'b0;
      end else if (wr_ok) begin
         if (wr_reg == erlt_pkg::ERLT_REG_IEN) begin
            ien_q <= wbyte_q[0];
         end
         if (wr_reg == erlt_pkg::ERLT_REG_EDGE) begin
            edge_sel_q <= wbyte_q[0];
         end
      end
   end

   // reload register is write-only behind the counter address
   assign load = wr_ok && wr_reg == erlt_pkg::ERLT_REG_COUNT;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         reload_q <= `ERLT_COUNT_RST;
      end else if (load) begin
         reload_q <= wbyte_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // count sources

   // falling edge of the chosen shared prescaler tap; a select change
   // may give one stray tick, which software must tolerate
   assign psc_bit = prescale_count[tap_of(mode_q.sel)];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         psc_prev_q <= 1'b0;
      end else begin
         psc_prev_q <= psc_bit;
      end
   end

   // event pin synchroniser; stage one feeds stage two only
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ev_s1_q <= 1'b0;
         ev_s2_q <= 1'b0;
         ev_s3_q <= 1'b0;
      end else begin
         ev_s1_q <= event_input_pin;
         ev_s2_q <= ev_s1_q;
         ev_s3_q <= ev_s2_q;
      end
   end

   // 1 counts rising edges, 0 falling edges
   assign ev_edge = edge_sel_q ? (ev_s2_q & ~ev_s3_q)
                               : (~ev_s2_q & ev_s3_q);

   assign tick = (mode_q.sel == erlt_pkg::ERLT_CLK_EXT) ? ev_edge
                                                        : (psc_prev_q & ~psc_bit);

   ////////////////////////////////////////////////////////////////////////////
   // counter

   // a write on the same edge as a tick wins; that tick is dropped
   assign ovf = tick & ~load & (count_q == `ERLT_COUNT_TOP);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count_q <= `ERLT_COUNT_RST;
      end else if (load) begin
         count_q <= wbyte_q;
      end else if (ovf) begin
         count_q <= mode_q.reload ? reload_q
                                  : `ERLT_COUNT_RST;
      end else if (tick) begin
         count_q <= 8'(count_q + 8'h01);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // overflow flag and interrupt request

   // writing 0 to bit 0 clears; a same-cycle overflow keeps it set
   assign clr = wr_ok && wr_reg == erlt_pkg::ERLT_REG_IRQ && !wbyte_q[0];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flag_q <= 1'b0;
      end else if (ovf) begin
         flag_q <= 1'b1;
      end else if (clr) begin
         flag_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= flag_q & ien_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs

   assign s_axi_awready = awready_q;
   assign s_axi_wready  = wready_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rdata   = rdata_q;
   assign s_axi_rresp   = rresp_q;
   assign cpu_irq       = irq_q;

   ////////////////////////////////////////////////////////////////////////////
   // checks

   localparam int WR_LAT_MIN = 1;
   localparam int WR_LAT_MAX = 1;

   sequence s_overflow;
      tick && !load && count_q == `ERLT_COUNT_TOP;
   endsequence

   sequence s_plain_step;
      tick && !load && count_q != `ERLT_COUNT_TOP;
   endsequence

   chk_mode_reset_value: assert property (
      @(posedge aclk) $rose(aresetn) |-> mode_q == erlt_pkg::erlt_mode_s'(4'h0)
         && count_q == 8'h00 && reload_q == 8'h00)
      else $error("mode or counter not at reset value");

   chk_rsvd_read_ones: assert property (
      @(posedge aclk) disable iff (!aresetn)
      ar_take && rd_reg == erlt_pkg::ERLT_REG_MODE |=> s_axi_rdata[6:3] == 4'hf)
      else $error("reserved mode bits not read as one");

   chk_interval_wrap: assert property (
      @(posedge aclk) disable iff (!aresetn)
      s_overflow and !mode_q.reload |=> count_q == 8'h00 && flag_q)
      else $error("interval overflow did not wrap to zero");

   chk_reload_on_ovf: assert property (
      @(posedge aclk) disable iff (!aresetn)
      s_overflow and mode_q.reload |=> count_q == $past(reload_q))
      else $error("auto-reload overflow did not load reload value");

   chk_write_loads: assert property (
      @(posedge aclk) disable iff (!aresetn)
      load |=> count_q == $past(wbyte_q) && reload_q == count_q)
      else $error("reload write did not load counter");

   chk_count_step: assert property (
      @(posedge aclk) disable iff (!aresetn)
      s_plain_step |=> count_q == 8'($past(count_q) + 8'h01))
      else $error("counter did not advance by one");

   chk_count_still: assert property (
      @(posedge aclk) disable iff (!aresetn)
      !tick && !load |=> $stable(count_q))
      else $error("counter moved without a count input");

   chk_flag_sticky: assert property (
      @(posedge aclk) disable iff (!aresetn)
      flag_q && !clr |=> flag_q)
      else $error("request flag dropped without a clear");

   chk_irq_gating: assert property (
      @(posedge aclk) disable iff (!aresetn)
      s_overflow ##1 (flag_q && ien_q) |=> cpu_irq)
      else $error("enabled overflow gave no interrupt");

   chk_irq_masked: assert property (
      @(posedge aclk) disable iff (!aresetn)
      cpu_irq |-> $past(flag_q) && $past(ien_q))
      else $error("interrupt without enabled flag");

   chk_write_resp_time: assert property (
      @(posedge aclk) disable iff (!aresetn)
      do_wr |-> ##[WR_LAT_MIN:WR_LAT_MAX] s_axi_bvalid)
      else $error("write response late");

endmodule

// [erlt_defines.svh]
`ifndef ERLT_DEFINES_SVH
`define ERLT_DEFINES_SVH

`define ERLT_ADDR_W      18
// register indices; byte address is four times the index
`define ERLT_IDX_MODE    16'hffc2
`define ERLT_IDX_COUNT   16'hffc3
`define ERLT_IDX_IRQ     16'h0020
`define ERLT_IDX_IEN     16'h0021
`define ERLT_IDX_EDGE    16'h0022
// reset values and field layout
`define ERLT_MODE_RST    8'h78
`define ERLT_MODE_RSVD   8'h78
`define ERLT_BIT_RELOAD  7
`define ERLT_COUNT_RST   8'h00
`define ERLT_COUNT_TOP   8'hff
// prescaler tap bits for /8192 /2048 /512 /256 /128 /32 /8
`define ERLT_PSC_W       13
`define ERLT_TAP_8192    4'hc
`define ERLT_TAP_2048    4'ha
`define ERLT_TAP_512     4'h8
`define ERLT_TAP_256     4'h7
`define ERLT_TAP_128     4'h6
`define ERLT_TAP_32      4'h4
`define ERLT_TAP_8       4'h2
// bus responses
`define ERLT_RESP_OKAY   2'h0
`define ERLT_RESP_SLVERR 2'h2

`endif

// [erlt_pkg.sv]
package erlt_pkg;

   // counter clock choice held in mode bits 2..0
   typedef enum logic [2:0] {
      ERLT_CLK_8192 = 3'h0,
      ERLT_CLK_2048 = 3'h1,
      ERLT_CLK_512  = 3'h2,
      ERLT_CLK_256  = 3'h3,
      ERLT_CLK_128  = 3'h4,
      ERLT_CLK_32   = 3'h5,
      ERLT_CLK_8    = 3'h6,
      ERLT_CLK_EXT  = 3'h7
   } erlt_clk_e;

   // register decode result
   typedef enum logic [2:0] {
      ERLT_REG_NONE  = 3'h0,
      ERLT_REG_MODE  = 3'h1,
      ERLT_REG_COUNT = 3'h2,
      ERLT_REG_IRQ   = 3'h3,
      ERLT_REG_IEN   = 3'h4,
      ERLT_REG_EDGE  = 3'h5
   } erlt_reg_e;

   // writable part of the mode register
   typedef struct packed {
      logic      reload;
      erlt_clk_e sel;
   } erlt_mode_s;

endpackage

// [erlt_far_model.sv]
`timescale 1ns/1ps
`include "erlt_defines.svh"

module erlt_far_model (
   input  wire logic                   aclk,
   input  wire logic                   aresetn,
   output logic [`ERLT_PSC_W-1:0]      prescale_count,
   output logic                        event_input_pin
);

   ////////////////////////////////////////////////////////////////////////////////
   // shared system prescaler, cleared with the chip so tap phase is known
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prescale_count <= '0;
      end else begin
         prescale_count <= prescale_count + 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // pin already routed to the event function, its own interrupt masked
   initial event_input_pin = 1'b0;

   // each level held 4 cycles so the synchroniser never misses an edge
   task automatic send_events(input int n);
      for (int i = 0; i < n; i++) begin
         repeat (4) @(posedge aclk);
         event_input_pin <= 1'b1;
         repeat (4) @(posedge aclk);
         event_input_pin <= 1'b0;
      end
      repeat (6) @(posedge aclk);
   endtask

endmodule

// [eight_bit_reload_event_timer_bench.sv]
`timescale 1ns/1ps
`include "erlt_defines.svh"

module eight_bit_reload_event_timer_bench;

   localparam logic [17:0] a_mode  = {`ERLT_IDX_MODE, 2'b00};
   localparam logic [17:0] a_count = {`ERLT_IDX_COUNT, 2'b00};
   localparam logic [17:0] a_irq   = {`ERLT_IDX_IRQ, 2'b00};
   localparam logic [17:0] a_ien   = {`ERLT_IDX_IEN, 2'b00};
   localparam logic [17:0] a_edge  = {`ERLT_IDX_EDGE, 2'b00};
   localparam logic [17:0] a_none  = 18'h00010;

   logic                    aclk;
   logic                    aresetn;
   logic [`ERLT_ADDR_W-1:0] awaddr;
   logic                    awvalid;
   logic                    awready;
   logic [31:0]             wdata;
   logic [3:0]              wstrb;
   logic                    wvalid;
   logic                    wready;
   logic [1:0]              bresp;
   logic                    bvalid;
   logic                    bready;
   logic [`ERLT_ADDR_W-1:0] araddr;
   logic                    arvalid;
   logic                    arready;
   logic [31:0]             rdata;
   logic [1:0]              rresp;
   logic                    rvalid;
   logic                    rready;
   logic [`ERLT_PSC_W-1:0]  psc;
   logic                    pin;
   logic                    cpu_irq;
   int                      n_mismatch;
   int                      num_checks;
   logic [31:0]             rd_val;
   logic [1:0]              resp;
   int                      div_tab [7] = '{8192, 2048, 512, 256, 128, 32, 8};

   erlt_timer dut_u (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .prescale_count(psc),
      .event_input_pin(pin), .cpu_irq(cpu_irq)
   );

   erlt_far_model far_u (
      .aclk(aclk), .aresetn(aresetn), .prescale_count(psc), .event_input_pin(pin)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // 25 MHz clock
   initial begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end

   // hang guard, about two and a half times the expected run
   initial begin
      repeat (100000) @(posedge aclk);
      n_mismatch++;
      print_verdict();
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
         n_mismatch++;
      end
   endtask

   // counts from the internal taps depend on read latency, so a window
   task automatic check_rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
      num_checks++;
      if ((^got === 1'bx) || got < lo || got > hi) begin
         $display("FAIL t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
         n_mismatch++;
      end
   endtask

   // address and data offered together, each released once taken
   task automatic axi_wr(input logic [17:0] a, input logic [31:0] d, input logic [3:0] s,
                         output logic [1:0] r);
      bit aw_ok = 1'b0;
      bit w_ok = 1'b0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (int i = 0; i < 64 && !(aw_ok && w_ok); i++) begin
         @(posedge aclk);
         // each half drops its valid at the edge that takes it
         aw_ok = aw_ok | awready;
         w_ok  = w_ok | wready;
         awvalid <= !aw_ok;
         wvalid  <= !w_ok;
      end
      for (int i = 0; i < 64 && !bvalid; i++) @(posedge aclk);
      r = bvalid ? bresp : 2'bxx;
      bready <= 1'b0;
   endtask

   task automatic axi_rd(input logic [17:0] a, output logic [31:0] d, output logic [1:0] r);
      bit ar_ok = 1'b0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (int i = 0; i < 64 && !ar_ok; i++) begin
         @(posedge aclk);
         ar_ok = arready;
         arvalid <= !ar_ok;
      end
      for (int i = 0; i < 64 && !rvalid; i++) @(posedge aclk);
      d = rvalid ? rdata : 'x;
      r = rvalid ? rresp : 2'bxx;
      rready <= 1'b0;
   endtask

   task automatic wr(input logic [17:0] a, input logic [7:0] d);
      logic [1:0] r;
      axi_wr(a, d, 4'hf, r);
      check(r, `ERLT_RESP_OKAY);
   endtask

   task automatic rd(input logic [17:0] a, input logic [7:0] exp);
      logic [31:0] d;
      logic [1:0]  r;
      axi_rd(a, d, r);
      check(r, `ERLT_RESP_OKAY);
      check(d, {24'h000000, exp});
   endtask

   task automatic tend(input string name);
      $display("test %s done at %0t", name, $time);
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic chip_reset();
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
      {araddr, arvalid, rready} = '0;
      n_mismatch = 0;
      num_checks = 0;
      aresetn = 1'b0;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      // reset values, unmapped read, free counting with no setup
      rd(a_mode, 8'h78);
      rd(a_count, 8'h00);
      rd(a_irq, 8'h00);
      rd(a_ien, 8'h00);
      rd(a_edge, 8'h00);
      axi_rd(a_none, rd_val, resp);
      check(resp, `ERLT_RESP_SLVERR);
      check(rd_val, 32'h00000000);
      repeat (16384) @(posedge aclk);
      axi_rd(a_count, rd_val, resp);
      check_rng(rd_val, 2, 3);
      tend("reset state");
      // reserved bits, mode bit, ignored and refused writes
      wr(a_mode, 8'h00);
      rd(a_mode, 8'h78);
      wr(a_mode, 8'h86);
      rd(a_mode, 8'hfe);
      axi_wr(a_mode, 8'h00, 4'h0, resp);
      check(resp, `ERLT_RESP_OKAY);
      rd(a_mode, 8'hfe);
      // upper byte lanes carry junk that must be ignored
      axi_wr(a_mode, 32'h8686_8601, 4'h1, resp);
      check(resp, `ERLT_RESP_OKAY);
      rd(a_mode, 8'h79);
      axi_wr(a_none, 8'h55, 4'hf, resp);
      check(resp, `ERLT_RESP_SLVERR);
      tend("mode register");
      // every internal rate from the shared prescaler
      for (int s = 0; s < 7; s++) begin
         wr(a_mode, 8'h78 | 8'(s));
         wr(a_count, 8'h00);
         repeat (2 * div_tab[s]) @(posedge aclk);
         axi_rd(a_count, rd_val, resp);
         check_rng(rd_val, 2, 3);
      end
      tend("internal rates");
      // interval mode on event edges
      wr(a_mode, 8'h07);
      wr(a_edge, 8'h01);
      wr(a_count, 8'hfd);
      rd(a_count, 8'hfd);
      rd(a_count, 8'hfd);
      far_u.send_events(2);
      rd(a_count, 8'hff);
      rd(a_irq, 8'h00);
      far_u.send_events(1);
      rd(a_count, 8'h00);
      rd(a_irq, 8'h01);
      check(cpu_irq, 1'b0);
      wr(a_ien, 8'h01);
      repeat (2) @(negedge aclk);
      check(cpu_irq, 1'b1);
      wr(a_edge, 8'h00);
      far_u.send_events(4);
      rd(a_count, 8'h04);
      wr(a_irq, 8'h01);
      rd(a_irq, 8'h01);
      wr(a_irq, 8'h00);
      rd(a_irq, 8'h00);
      check(cpu_irq, 1'b0);
      tend("interval events");
      // auto-reload with short periods
      wr(a_mode, 8'h87);
      wr(a_edge, 8'h01);
      wr(a_count, 8'hfe);
      rd(a_count, 8'hfe);
      far_u.send_events(2);
      rd(a_count, 8'hfe);
      rd(a_irq, 8'h01);
      wr(a_count, 8'hff);
      far_u.send_events(1);
      rd(a_count, 8'hff);
      tend("auto reload");
      // second reset must clear the reload value too
      chip_reset();
      rd(a_mode, 8'h78);
      wr(a_mode, 8'h87);
      wr(a_edge, 8'h01);
      far_u.send_events(255);
      rd(a_count, 8'hff);
      rd(a_irq, 8'h00);
      far_u.send_events(1);
      rd(a_count, 8'h00);
      rd(a_irq, 8'h01);
      tend("reload after reset");
      print_verdict();
   end

endmodule
